// [design/mic_irq_ctrl.sv]
// interrupt controller: request flags, enables, multi-function groups, vectored call
// assumes a classic wishbone master and a core that pushes ret_pc and jumps on call
//
// How it works
// - source events other than the pin set their flag whatever the enables hold
// - a flag whose own enable is low stays set but never calls
// - global enable low suppresses every call
// - a call hands next pc for the push and loads the source vector
// - return from service pops the saved pc; routines end with it
// - accepting any call clears the global enable
// - requests while blocked still set and hold their flags
// - software may set global enable inside a routine to allow nesting
// - no call is accepted while the core stack is full
// - simultaneous requests resolve by fixed priority, one accepted
// - any flag becoming set pulses the wake output
// - selected pin transition sets the external flag
// - external call needs global and external enables, room, and its flag, set by the edge or by software
// - pin acts as interrupt input only while external enable is set
// - servicing the external call clears its flag and global enable
// - edge select offers rising, falling, both or off
// - edge codes: 00 off, 01 rising, 10 falling, 11 both
// - group flag sets when any member flag sets; enabled group calls
// - group service clears group flag and global enable, members stay
// - a member needs its own and its group enable to call
// - timer-1 group: a flag bit5, p flag bit4, a enable bit1, p enable bit0
// - group two: eeprom flag bit5, low voltage bit4, enables bit1 and bit0
// - unused group bits read zero, all bits reset to zero
// - overcurrent sets its flag; call clears flag and global enable
`include "mic_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module mic_irq_ctrl (
    input  wire logic                 mclk_i,          // system clock, 25 MHz
    input  wire logic                 arst_n_i,        // async reset, active low
    input  wire logic                 wb_cyc_i,        // wishbone cycle
    input  wire logic                 wb_stb_i,        // wishbone strobe
    input  wire logic                 wb_we_i,         // wishbone write
    input  wire logic [7:0]           wb_adr_i,        // wishbone byte address
    input  wire logic [3:0]           wb_sel_i,        // wishbone byte enables
    input  wire logic [31:0]          wb_dat_i,        // wishbone write data
    output logic      [31:0]          wb_dat_o,        // wishbone read data
    output logic                      wb_ack_o,        // wishbone acknowledge
    input  wire logic                 ext_irq_pin_i,   // external interrupt pin
    input  wire logic                 ocp_evt_i,       // overcurrent detected pulse
    input  wire logic [5:0]           mem_evt_i,       // member source event pulses
    input  wire logic                 core_ready_i,    // core at instruction boundary
    input  wire logic                 stack_full_i,    // core call stack full
    input  wire logic [`MIC_PC_W-1:0] core_next_pc_i,  // address of next instruction
    input  wire logic                 return_from_isr_i, // return instruction executed
    output logic                      call_o,          // vectored call pulse
    output logic      [`MIC_PC_W-1:0] vector_o,        // vector to load into pc
    output logic      [`MIC_PC_W-1:0] ret_pc_o,        // pc to push on the stack
    output logic                      pop_o,           // pop saved pc from stack
    output logic                      wake_o           // wake from sleep or idle
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    mic_pkg::mic_state_t q;
    mic_pkg::mic_state_t d;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // vector for a source index
    function automatic logic [`MIC_PC_W-1:0] vec_of(input logic [2:0] idx);
        logic [`MIC_PC_W-1:0] v;
        v = `MIC_VEC_MF2;
        unique case (idx)
            3'h0:    v = `MIC_VEC_EXT;
            3'h1:    v = `MIC_VEC_OCP;
            3'h2:    v = `MIC_VEC_MF0;
            3'h3:    v = `MIC_VEC_MF1;
            default: v = `MIC_VEC_MF2;
        endcase
        return v;
    endfunction

    // register read mux; unmapped and unused bits read zero
    function automatic logic [7:0] rd_reg(input logic [5:0] idx,
                                          input mic_pkg::mic_state_t s,
                                          input logic full);
        logic [7:0] r;
        r = `MIC_RST_REG;
        unique case (idx)
            `MIC_IDX_CTRL0:
            begin
                r[`MIC_B_GIE]      = s.gie;
                r[`MIC_B_OCP_EN]   = s.ocp_en;
                r[`MIC_B_OCP_FLAG] = s.ocp_flag;
            end
            `MIC_IDX_CTRL1:
            begin
                r[`MIC_B_GRP_EN+:3]   = s.grp_en;
                r[`MIC_B_GRP_FLAG+:3] = s.grp_flag;
            end
            `MIC_IDX_CTRL2:
            begin
                r[`MIC_B_EXT_EN]   = s.ext_en;
                r[`MIC_B_EXT_FLAG] = s.ext_flag;
            end
            `MIC_IDX_EDGE:
            begin
                r[`MIC_B_EDGE_LO+:2] = s.edge_sel;
            end
            `MIC_IDX_MFI0, `MIC_IDX_TIMER1_MATCH_IRQ_CTRL, `MIC_IDX_GROUP2_IRQ_CTRL:
            begin
                // member pairs: p at low bit, a (or eeprom) at high bit
                r[`MIC_B_MEM_EN+:2]   = s.mem_en[2*(idx-`MIC_IDX_MFI0)+:2];
                r[`MIC_B_MEM_FLAG+:2] = s.mem_flag[2*(idx-`MIC_IDX_MFI0)+:2];
            end
            `MIC_IDX_STAT:
            begin
                r[3:0]              = s.depth;
                r[`MIC_B_STAT_FULL] = full;
            end
            default: r = `MIC_RST_REG;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    // order inside: software write, then acceptance, then hardware sets,
    // so an event in the cycle of a clear is never lost
    always_comb
    begin
        logic       req;
        logic       wr;
        logic       rise;
        logic       fall;
        logic       ext_evt;
        logic [2:0] grp_call;
        logic [2:0] grp_rise;
        logic [`MIC_NSRC-1:0] pend;
        logic [2:0] win;
        logic       accept;
        logic [5:0] widx;
        req      = 1'b0;
        wr       = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        ext_evt  = 1'b0;
        grp_call = 3'h0;
        grp_rise = 3'h0;
        pend     = '0;
        win      = 3'h0;
        accept   = 1'b0;
        widx     = wb_adr_i[7:2];
        d        = q;
        d.call   = 1'b0;
        d.wake   = 1'b0;

        // bus: answer one cycle after the request, write lands with ack
        req   = wb_cyc_i & wb_stb_i;
        d.ack = req & ~q.ack;
        if (req & ~q.ack)
        begin
            d.rdata = rd_reg(widx, q, stack_full_i);
        end
        wr = req & wb_we_i & q.ack & wb_sel_i[0];
        if (wr)
        begin
            unique case (widx)
                `MIC_IDX_CTRL0:
                begin
                    d.gie      = wb_dat_i[`MIC_B_GIE];
                    d.ocp_en   = wb_dat_i[`MIC_B_OCP_EN];
                    d.ocp_flag = wb_dat_i[`MIC_B_OCP_FLAG];
                end
                `MIC_IDX_CTRL1:
                begin
                    d.grp_en   = wb_dat_i[`MIC_B_GRP_EN+:3];
                    d.grp_flag = wb_dat_i[`MIC_B_GRP_FLAG+:3];
                end
                `MIC_IDX_CTRL2:
                begin
                    d.ext_en   = wb_dat_i[`MIC_B_EXT_EN];
                    d.ext_flag = wb_dat_i[`MIC_B_EXT_FLAG];
                end
                `MIC_IDX_EDGE:
                begin
                    d.edge_sel = wb_dat_i[`MIC_B_EDGE_LO+:2];
                end
                `MIC_IDX_MFI0, `MIC_IDX_TIMER1_MATCH_IRQ_CTRL, `MIC_IDX_GROUP2_IRQ_CTRL:
                begin
                    d.mem_en[2*(widx-`MIC_IDX_MFI0)+:2]   = wb_dat_i[`MIC_B_MEM_EN+:2];
                    d.mem_flag[2*(widx-`MIC_IDX_MFI0)+:2] = wb_dat_i[`MIC_B_MEM_FLAG+:2];
                end
                default:
                begin
                    d.gie = d.gie;  // status and unmapped: write ignored
                end
            endcase
        end

        // pin: sync[0] feeds only sync[1]; level moves once sync[1] and sync[2] agree
        d.sync = {q.sync[1:0], ext_irq_pin_i};
        if (q.sync[1] == q.sync[2])
        begin
            d.pin_lvl = q.sync[2];
        end
        rise    = ~q.pin_lvl & d.pin_lvl;
        fall    = q.pin_lvl & ~d.pin_lvl;
        // pin is ignored unless the external enable claims it
        ext_evt = q.ext_en & ((q.edge_sel[0] & rise) | (q.edge_sel[1] & fall));

        // pending requests from the current state
        for (int g = 0; g < 3; g++)
        begin
            // member counts only with its own enable and its group's
            grp_call[g] = q.grp_flag[g] & q.grp_en[g] &
                          |(q.mem_flag[2*g+:2] & q.mem_en[2*g+:2]);
        end
        pend[0] = q.ext_flag & q.ext_en;
        pend[1] = q.ocp_flag & q.ocp_en;
        pend[4:2] = grp_call;
        // lowest index, lowest vector, wins
        for (int i = `MIC_NSRC - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                win = 3'(i);
            end
        end
        // global enable, stack room, and an instruction boundary
        accept = q.gie & |pend & ~stack_full_i & core_ready_i;

        if (accept)
        begin
            d.call   = 1'b1;
            d.vector = vec_of(win);
            d.ret_pc = core_next_pc_i;
            d.gie    = 1'b0;
            unique case (win)
                3'h0:    d.ext_flag = 1'b0;
                3'h1:    d.ocp_flag = 1'b0;
                3'h2:    d.grp_flag[0] = 1'b0;    // members stay set
                3'h3:    d.grp_flag[1] = 1'b0;
                default: d.grp_flag[2] = 1'b0;
            endcase
        end

        // nesting depth: up on call, down on return; saturates both ways
        if (accept & ~return_from_isr_i & (q.depth != 4'hf))
        begin
            d.depth = q.depth + 4'h1;
        end
        else if (return_from_isr_i & ~accept & (q.depth != 4'h0))
        begin
            d.depth = q.depth - 4'h1;
        end

        // hardware sets last so they beat any clear; only the external enable plays a part, gating the pin
        d.mem_flag = d.mem_flag | mem_evt_i;
        d.ocp_flag = d.ocp_flag | ocp_evt_i;
        d.ext_flag = d.ext_flag | ext_evt;
        for (int g = 0; g < 3; g++)
        begin
            grp_rise[g] = |(d.mem_flag[2*g+:2] & ~q.mem_flag[2*g+:2]);
        end
        d.grp_flag = d.grp_flag | grp_rise;

        // wake only on a flag going from clear to set
        d.wake = (d.ocp_flag & ~q.ocp_flag) | (d.ext_flag & ~q.ext_flag) |
                 |(d.mem_flag & ~q.mem_flag) | |(d.grp_flag & ~q.grp_flag);
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    // every field clears at reset, so all enables and flags start at zero
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // pop is a straight handshake to the stack; the core owns the pc storage
    assign wb_dat_o = {24'h000000, q.rdata};
    assign wb_ack_o = q.ack;
    assign call_o   = q.call;
    assign vector_o = q.vector;
    assign ret_pc_o = q.ret_pc;
    assign pop_o    = return_from_isr_i;
    assign wake_o   = q.wake;

endmodule // mic_irq_ctrl

`default_nettype wire

// [design/mic_defines.svh]
// register indices, field positions, reset values and vectors of the interrupt controller
// assumes a 32-bit classic wishbone bus with byte addresses; a register sits at 4 * index
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register word indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define MIC_IDX_CTRL0      6'h00
`define MIC_IDX_CTRL1      6'h01
`define MIC_IDX_CTRL2      6'h02
`define MIC_IDX_EDGE       6'h03
`define MIC_IDX_MFI0       6'h04
`define MIC_IDX_TIMER1_MATCH_IRQ_CTRL       6'h05
`define MIC_IDX_GROUP2_IRQ_CTRL       6'h06
`define MIC_IDX_STAT       6'h07

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define MIC_B_GIE          0
`define MIC_B_OCP_EN       1
`define MIC_B_OCP_FLAG     4
`define MIC_B_GRP_EN       0
`define MIC_B_GRP_FLAG     4
`define MIC_B_EXT_EN       3
`define MIC_B_EXT_FLAG     7
`define MIC_B_EDGE_LO      2
`define MIC_B_MEM_EN       0
`define MIC_B_MEM_FLAG     4
`define MIC_B_STAT_FULL    7

// ----------------------------------------------------------------------------
// reset values and edge-select codes
// ----------------------------------------------------------------------------
`define MIC_RST_REG        8'h00
`define MIC_EDGE_OFF       2'h0
`define MIC_EDGE_RISE      2'h1
`define MIC_EDGE_FALL      2'h2
`define MIC_EDGE_BOTH      2'h3

// ----------------------------------------------------------------------------
// vector addresses, ascending = descending priority
// ----------------------------------------------------------------------------
`define MIC_PC_W           12
`define MIC_VEC_EXT        12'h004
`define MIC_VEC_OCP        12'h008
`define MIC_VEC_MF0        12'h00c
`define MIC_VEC_MF1        12'h010
`define MIC_VEC_MF2        12'h014
`define MIC_NSRC           5

`endif

// [design/mic_pkg.sv]
// types of the interrupt controller
// assumes mic_defines.svh is on the include path
`include "mic_defines.svh"

package mic_pkg;

    // source index order equals priority order, lowest index wins
    typedef enum logic [2:0] {
        MIC_SRC_EXT,
        MIC_SRC_OCP,
        MIC_SRC_MF0,
        MIC_SRC_MF1,
        MIC_SRC_MF2
    } mic_src_t;

    // whole state of the controller
    typedef struct packed {
        logic                 gie;
        logic                 ocp_en;
        logic                 ocp_flag;
        logic [2:0]           grp_en;
        logic [2:0]           grp_flag;
        logic                 ext_en;
        logic                 ext_flag;
        logic [1:0]           edge_sel;
        logic [5:0]           mem_en;     // 0 t0p,1 t0a,2 t1p,3 t1a,4 lv,5 ee
        logic [5:0]           mem_flag;
        logic [2:0]           sync;
        logic                 pin_lvl;
        logic                 ack;
        logic [7:0]           rdata;
        logic                 call;
        logic [`MIC_PC_W-1:0] vector;
        logic [`MIC_PC_W-1:0] ret_pc;
        logic [3:0]           depth;
        logic                 wake;
    } mic_state_t;

endpackage

// [dv/mic_core_model.sv]
// behavioural processor core seen by the interrupt controller: pc, stack report, return
// assumes the bench commands stack-full, slow acceptance and each return pulse
`include "mic_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module mic_core_model (
    input  wire logic                 mclk_i,       // system clock
    input  wire logic                 arst_n_i,     // async reset, active low
    input  wire logic                 call_i,       // call pulse from controller
    input  wire logic [`MIC_PC_W-1:0] vector_i,     // vector to jump to
    input  wire logic                 slow_i,       // take calls only now and then
    input  wire logic                 full_i,       // report a full stack
    input  wire logic                 ret_req_i,    // bench asks for a return
    output logic                      core_ready_o, // at instruction boundary
    output logic                      stack_full_o, // stack full report
    output logic      [`MIC_PC_W-1:0] next_pc_o,    // address of next instruction
    output logic                      return_o      // return executed
);
    logic [7:0] lfsr_q;

    // ---------------------------------------------------------------
    // pc and boundary timing
    // ---------------------------------------------------------------
    // a running lfsr makes the slow core refuse calls on irregular cycles
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lfsr_q    <= 8'h5a;
            next_pc_o <= 12'h100;
            return_o  <= 1'b0;
        end
        else
        begin
            lfsr_q    <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            next_pc_o <= call_i ? vector_i : next_pc_o + 12'h001;
            return_o  <= ret_req_i;
        end
    end

    assign core_ready_o = !slow_i || lfsr_q[0];
    assign stack_full_o = full_i;
endmodule // mic_core_model

`default_nettype wire

// [dv/mic_irq_ctrl_checker.sv]
// concurrent checks on the ports of the interrupt controller
// assumes one clock domain and the async active-low reset
`include "mic_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module mic_irq_ctrl_checker (
    input wire logic                 mclk_i,            // system clock
    input wire logic                 arst_n_i,          // async reset
    input wire logic                 wb_cyc_i,          // bus cycle
    input wire logic                 wb_stb_i,          // bus strobe
    input wire logic [31:0]          wb_dat_o,          // read data
    input wire logic                 wb_ack_o,          // acknowledge
    input wire logic                 core_ready_i,      // core boundary
    input wire logic                 stack_full_i,      // stack full
    input wire logic [`MIC_PC_W-1:0] core_next_pc_i,    // next pc
    input wire logic                 return_from_isr_i, // return executed
    input wire logic                 call_o,            // call pulse
    input wire logic [`MIC_PC_W-1:0] vector_o,          // vector
    input wire logic [`MIC_PC_W-1:0] ret_pc_o,          // pc to push
    input wire logic                 pop_o              // pop request
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ---------------------------------------------------------------
    // bus handshake in steps
    // ---------------------------------------------------------------
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_wb_ack_once: assert property (s_req |=> s_ack_once)
        else $error("bus ack not a single pulse after request");
    a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_call_ready: assert property (call_o |-> $past(core_ready_i && !stack_full_i))
        else $error("call while core busy or stack full");
    a_full_blocks: assert property (stack_full_i ##1 stack_full_i |-> !call_o)
        else $error("call during full stack");
    a_call_single: assert property (call_o |=> !call_o)
        else $error("call longer than one cycle");
    a_push_pc: assert property (call_o |-> ret_pc_o == $past(core_next_pc_i))
        else $error("pushed pc differs from next pc");
    a_vec_legal: assert property (call_o |-> vector_o inside {`MIC_VEC_EXT, `MIC_VEC_OCP,
        `MIC_VEC_MF0, `MIC_VEC_MF1, `MIC_VEC_MF2})
        else $error("call to an unknown vector");
    a_vec_hold: assert property (!call_o |-> $stable(vector_o) && $stable(ret_pc_o))
        else $error("vector or pushed pc moved without call");
    a_pop_follow: assert property (pop_o == return_from_isr_i)
        else $error("pop does not follow return");
endmodule // mic_irq_ctrl_checker

bind mic_irq_ctrl mic_irq_ctrl_checker mic_irq_ctrl_checker_i (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_ready_i(core_ready_i),
    .stack_full_i(stack_full_i), .core_next_pc_i(core_next_pc_i),
    .return_from_isr_i(return_from_isr_i), .call_o(call_o), .vector_o(vector_o),
    .ret_pc_o(ret_pc_o), .pop_o(pop_o));

`default_nettype wire

// [dv/mic_irq_ctrl_tb.sv]
// self-checking bench of the interrupt controller with a core model
// assumes the checker is bound by its own file; call and wake sampled at falling edges
`include "mic_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module mic_irq_ctrl_tb;
    logic        mclk_i = 1'b0, arst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        pin = 1'b0, ocp = 1'b0, slow = 1'b0, full = 1'b0, ret = 1'b0;
    logic [7:0]  adr = 8'h00, rbyte;
    logic [31:0] wdat = 32'h0, rdat;
    logic [5:0]  mev = 6'h00;
    logic        ack, call, pop, wake, rdy, sfull, rfi;
    logic [11:0] vec, rpc, npc, last_vec;
    int          fail_count = 0, n_tests = 0, n_calls = 0, n_wake = 0, seed = 35309;

    always #20 mclk_i = ~mclk_i;

    mic_irq_ctrl mic_irq_ctrl_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin_i(pin), .ocp_evt_i(ocp),
        .mem_evt_i(mev), .core_ready_i(rdy), .stack_full_i(sfull), .core_next_pc_i(npc),
        .return_from_isr_i(rfi), .call_o(call), .vector_o(vec), .ret_pc_o(rpc),
        .pop_o(pop), .wake_o(wake));
    mic_core_model mic_core_model_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .call_i(call),
        .vector_i(vec), .slow_i(slow), .full_i(full), .ret_req_i(ret), .core_ready_o(rdy),
        .stack_full_o(sfull), .next_pc_o(npc), .return_o(rfi));

    // one-cycle pulses are counted mid-cycle, clear of the edge that launches them
    always @(negedge mclk_i)
    begin
        if (call === 1'b1)
        begin
            n_calls++;
            last_vec = vec;
        end
        if (wake === 1'b1)
            n_wake++;
    end

    task automatic end_of_test;
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic single cycle; the request stands until ack is seen high
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h0, d};
        // ack and data are read as sampled at this edge, before the design updates
        @(posedge mclk_i);
        while (ack !== 1'b1 && n < 40)
        begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 40)
            fail_count++;
        rbyte = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic chk(input logic [5:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        cmp(rbyte, exp);
    endtask

    task automatic wcall(input logic [11:0] exp);
        int c0;
        int n;
        c0 = n_calls;
        n = 0;
        while (n_calls == c0 && n < 30)
        begin
            @(negedge mclk_i);
            n++;
        end
        cmp((n_calls != c0) ? last_vec : 12'hfff, exp);
    endtask

    task automatic nocall;
        int c0;
        c0 = n_calls;
        repeat (12) @(negedge mclk_i);
        cmp(12'(n_calls - c0), 12'h000);
    endtask

    task automatic pulse(input logic [5:0] m, input logic o, input logic r);
        @(posedge mclk_i);
        mev <= m;
        ocp <= o;
        ret <= r;
        @(posedge mclk_i);
        mev <= 6'h00;
        ocp <= 1'b0;
        ret <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        int k;
        int g;
        int w;
        logic [7:0] en;
        logic [7:0] fl;
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 9; i++)
            chk(6'(i), 8'h00);
        wr(`MIC_IDX_TIMER1_MATCH_IRQ_CTRL, 8'hff);
        chk(`MIC_IDX_TIMER1_MATCH_IRQ_CTRL, 8'h33);
        wr(`MIC_IDX_GROUP2_IRQ_CTRL, 8'hff);
        chk(`MIC_IDX_GROUP2_IRQ_CTRL, 8'h33);
        wr(`MIC_IDX_EDGE, 8'hff);
        chk(`MIC_IDX_EDGE, 8'h0c);
        wr(`MIC_IDX_TIMER1_MATCH_IRQ_CTRL, 8'h00);
        wr(`MIC_IDX_GROUP2_IRQ_CTRL, 8'h00);
        wr(`MIC_IDX_EDGE, 8'h00);
        wr(`MIC_IDX_CTRL1, 8'h00);
        // overcurrent: flag with enables off, wake once, then the gates in turn
        w = n_wake;
        pulse(6'h00, 1'b1, 1'b0);
        chk(`MIC_IDX_CTRL0, 8'h10);
        cmp(12'(n_wake - w), 12'h001);
        pulse(6'h00, 1'b1, 1'b0);
        cmp(12'(n_wake - w), 12'h001);
        wr(`MIC_IDX_CTRL0, 8'h11);
        nocall;
        wr(`MIC_IDX_CTRL0, 8'h12);
        nocall;
        wr(`MIC_IDX_CTRL0, 8'h13);
        wcall(`MIC_VEC_OCP);
        chk(`MIC_IDX_CTRL0, 8'h02);
        pulse(6'h00, 1'b0, 1'b1);
        // software-set flags, full stack, slow core, priority and nesting
        full <= 1'b1;
        wr(`MIC_IDX_CTRL2, 8'h88);
        wr(`MIC_IDX_CTRL0, 8'h13);
        nocall;
        chk(`MIC_IDX_STAT, 8'h80);
        slow <= 1'b1;
        full <= 1'b0;
        wcall(`MIC_VEC_EXT);
        chk(`MIC_IDX_CTRL2, 8'h08);
        wr(`MIC_IDX_CTRL0, 8'h13);
        wcall(`MIC_VEC_OCP);
        chk(`MIC_IDX_STAT, 8'h02);
        pulse(6'h00, 1'b0, 1'b1);
        pulse(6'h00, 1'b0, 1'b1);
        chk(`MIC_IDX_STAT, 8'h00);
        slow <= 1'b0;
        // every edge code against both pin transitions
        for (int c = 0; c < 4; c++)
        begin
            wr(`MIC_IDX_EDGE, 8'(c << 2));
            for (int l = 1; l >= 0; l--)
            begin
                wr(`MIC_IDX_CTRL2, 8'h08);
                pin <= l[0];
                repeat (8) @(posedge mclk_i);
                chk(`MIC_IDX_CTRL2, {(l[0] ? c[0] : c[1]), 7'h08});
            end
        end
        wr(`MIC_IDX_CTRL2, 8'h00);
        // with the external enable off the pin is not an interrupt input
        pin <= 1'b1;
        repeat (8) @(posedge mclk_i);
        chk(`MIC_IDX_CTRL2, 8'h00);
        // random members; odd rounds leave the member enable on
        for (int i = 0; i < 8; i++)
        begin
            k = {$random(seed)} % 6;
            g = k / 2;
            en = (i % 2 == 1) ? (8'h01 << (k % 2)) : 8'h00;
            fl = 8'h10 << (k % 2);
            wr(6'(`MIC_IDX_MFI0 + g), en);
            pulse(6'h01 << k, 1'b0, 1'b0);
            chk(`MIC_IDX_CTRL1, 8'h10 << g);
            wr(`MIC_IDX_CTRL1, 8'h11 << g);
            wr(`MIC_IDX_CTRL0, 8'h01);
            if (en != 8'h00)
                wcall(12'(`MIC_VEC_MF0 + 4 * g));
            else
                nocall;
            chk(6'(`MIC_IDX_MFI0 + g), en | fl);
            chk(`MIC_IDX_CTRL1, (en != 8'h00) ? (8'h01 << g) : (8'h11 << g));
            wr(6'(`MIC_IDX_MFI0 + g), 8'h00);
            wr(`MIC_IDX_CTRL1, 8'h00);
            wr(`MIC_IDX_CTRL0, 8'h00);
            pulse(6'h00, 1'b0, en != 8'h00);
        end
        end_of_test;
    end

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial
    begin
        #2000000;
        fail_count++;
        end_of_test;
    end
endmodule // mic_irq_ctrl_tb

`default_nettype wire
